// File: include/pmc_pkg.sv
`default_nettype none
package pmc_pkg;
    // ****************************************
    // Power modes and operating states
    // ****************************************
    typedef enum logic [1:0] {
        PM_ACTIVE = 2'b00,
        PM_SLEEP = 2'b01,
        PM_DEEP = 2'b10,
        PM_WAKE = 2'b11
    } powerMode_t;

    typedef enum logic [1:0] {
        OP_BOOT = 2'b00,
        OP_USER = 2'b01,
        OP_PRIV = 2'b10,
        OP_DEBUG = 2'b11
    } opState_t;

    // Protection modes, open is the only one allowing debug
    localparam logic [1:0] PROT_OPEN = 2'h0;

    // ****************************************
    // Wakeup source bit positions
    // ****************************************
    localparam int WK_GPIO = 0;
    localparam int WK_LPCOMP = 1;
    localparam int WK_SERIAL = 2;
    localparam int WK_WDOG = 3;
    localparam int WK_WIDTH = 4;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int ACQUIRE_WINDOW_NS = 2000;
    localparam int ACQUIRE_CYCLES = ACQUIRE_WINDOW_NS / CLK_PERIOD_NS;
    localparam int OSC_START_NS = 1000;
    localparam int OSC_START_CYCLES = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Clock and supply enables that travel together
    typedef struct packed {
        logic cpuClkEn;
        logic highFreqClockEn;
        logic systemBusClockEn;
        logic mainOscEn;
        logic highSpeedPeriphEn;
        logic activeRegEn;
        logic sramRetain;
        logic cpuRetain;
    } powerCtl_t;

    localparam powerCtl_t CTL_ACTIVE = 8'hFC;
endpackage
`default_nettype wire

// File: verilog/power_mode_controller.sv
// Overview of operation
// - Privileged state entered only by system call; runs fixed ROM code.
// - Leaving privileged state returns to user state.
// - Debug access is blocked while privileged.
// - Debug state entered only if debugger connects in reset acquire window.
// - Debug state allowed only when protection setting is open.
// - Three power modes: Active, Sleep, Deep-Sleep, decreasing power.
// - Active: CPU clocked, peripherals powered unless software disables them.
// - Sleep: CPU clock gated, SRAM retained, peripherals keep running.
// - Any enabled interrupt wakes Sleep back to Active.
// - Deep-Sleep: high and system clocks stopped, CPU/SRAM/fast logic retained.
// - Deep-Sleep: main oscillator and fast peripherals off, deep regulator only.
// - Deep-Sleep: low-speed and watch oscillators may optionally keep running.
// - Deep-Sleep: clockless or externally clocked peripherals keep operating.
// - Only GPIO, comparator, serial block and watchdog wake Deep-Sleep.
// - Reset pin or brownout returns Active from any mode.
// - Retained blocks keep state and resume on return to Active.
// - Wait-for-interrupt enters Sleep if select is 0, Deep-Sleep if 1.
// - Deep-Sleep before regulator ready goes Sleep, then Deep-Sleep automatically.
// - Reset without acquire enters boot with interrupts off, then user.
`default_nettype none
module power_mode_controller
    import pmc_pkg::*;
#(
    parameter int ACQ_CYCLES = ACQUIRE_CYCLES,
    parameter int OSC_CYCLES = OSC_START_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Reset causes
    input wire logic externalResetPin,
    input wire logic brownoutReset,
    // CPU requests
    input wire logic waitForInterrupt,
    input wire logic deepSleepSelect,
    input wire logic systemCall,
    input wire logic privExit,
    input wire logic bootDone,
    // Debug port
    input wire logic debugConnect,
    input wire logic debugReq,
    input wire logic [1:0] protMode,
    // Wakeup and oscillator status
    input wire logic [WK_WIDTH-1:0] deepWakeIrq,
    input wire logic anyEnabledIrq,
    input wire logic deepRegulatorReady,
    input wire logic lowSpeedOscKeep,
    input wire logic watchCrystalOscKeep,
    // Controls
    output powerCtl_t powerCtl,
    output logic lowSpeedOscEn,
    output logic watchCrystalOscEn,
    output logic irqEnable,
    output logic debugGrant,
    output logic romExec,
    // Status
    output powerMode_t powerMode,
    output opState_t opState
);

    // ****************************************
    // Shared state
    // ****************************************
    powerMode_t powerMode_r;
    powerMode_t powerMode_nxt;
    opState_t opState_r;
    opState_t opState_nxt;
    logic [15:0] acqCnt_r;
    logic [15:0] oscCnt_r;
    logic inAcquire;
    logic fullReset;
    logic deepWake;
    logic deepPend_r;

    // ****************************************
    // Helpers
    // ****************************************
    // Deep-Sleep may be entered only once the deep regulator reports ready
    function automatic logic deepAllowed(input logic wantDeep, input logic regReady);
        return wantDeep && regReady;
    endfunction

    // Full restart on reset pin or brownout
    assign fullReset = sys_rst | externalResetPin | brownoutReset;
    assign inAcquire = acqCnt_r != 16'h0000;
    // Only low-speed and asynchronous sources count in Deep-Sleep
    assign deepWake = |deepWakeIrq;

    // ****************************************
    // Acquire window after reset
    // ****************************************
    // Counts down the debugger acquire window from the end of reset
    always_ff @(posedge mclk) begin
        if (fullReset) begin
            acqCnt_r <= ACQ_CYCLES[15:0];
        end else if (inAcquire) begin
            acqCnt_r <= acqCnt_r - 16'h0001;
        end
    end

    // ****************************************
    // Operating state
    // ****************************************
    // Next operating state from CPU and debugger events
    always_comb begin
        opState_nxt = opState_r;
        unique case (opState_r)
            OP_BOOT: begin
                if (inAcquire && debugConnect && protMode == PROT_OPEN) begin
                    opState_nxt = OP_DEBUG;
                end else if (!inAcquire && bootDone) begin
                    opState_nxt = OP_USER;
                end
            end
            OP_USER: begin
                if (systemCall) begin
                    opState_nxt = OP_PRIV;
                end
            end
            OP_PRIV: begin
                if (privExit) begin
                    opState_nxt = OP_USER;
                end
            end
            OP_DEBUG: begin
                opState_nxt = OP_DEBUG;
            end
        endcase
    end

    // Operating state register
    always_ff @(posedge mclk) begin
        if (fullReset) begin
            opState_r <= OP_BOOT;
        end else begin
            opState_r <= opState_nxt;
        end
    end

    // Privilege, interrupt and debug outputs
    always_ff @(posedge mclk) begin
        if (fullReset) begin
            romExec <= 1'b1;
            irqEnable <= 1'b0;
            debugGrant <= 1'b0;
        end else begin
            romExec <= opState_nxt == OP_BOOT || opState_nxt == OP_PRIV;
            irqEnable <= opState_nxt != OP_BOOT;
            debugGrant <= debugReq && opState_nxt == OP_DEBUG;
        end
    end

    // ****************************************
    // Power mode
    // ****************************************
    // Next power mode from sleep requests and wakeups
    always_comb begin
        powerMode_nxt = powerMode_r;
        unique case (powerMode_r)
            PM_ACTIVE: begin
                if (waitForInterrupt) begin
                    if (deepAllowed(deepSleepSelect, deepRegulatorReady)) begin
                        powerMode_nxt = PM_DEEP;
                    end else begin
                        powerMode_nxt = PM_SLEEP;
                    end
                end
            end
            PM_SLEEP: begin
                if (anyEnabledIrq) begin
                    powerMode_nxt = PM_ACTIVE;
                end else if (deepAllowed(deepPend_r, deepRegulatorReady)) begin
                    powerMode_nxt = PM_DEEP;
                end
            end
            PM_DEEP: begin
                if (deepWake) begin
                    powerMode_nxt = PM_WAKE;
                end
            end
            PM_WAKE: begin
                if (oscCnt_r == 16'h0000) begin
                    powerMode_nxt = PM_ACTIVE;
                end
            end
        endcase
    end

    // Power mode register
    always_ff @(posedge mclk) begin
        if (fullReset) begin
            powerMode_r <= PM_ACTIVE;
        end else begin
            powerMode_r <= powerMode_nxt;
        end
    end

    // Sticky deep-sleep selection latched at sleep entry
    // The select line is a level from the core that may drop after the request,
    // so the wish for Deep-Sleep is kept here until Sleep is left
    always_ff @(posedge mclk) begin
        if (fullReset) begin
            deepPend_r <= 1'b0;
        end else if (powerMode_r == PM_ACTIVE && waitForInterrupt) begin
            deepPend_r <= deepSleepSelect;
        end else if (powerMode_nxt != PM_SLEEP) begin
            deepPend_r <= 1'b0;
        end
    end

    // Oscillator start-up timer during Deep-Sleep wake
    always_ff @(posedge mclk) begin
        if (fullReset) begin
            oscCnt_r <= 16'h0000;
        end else if (powerMode_nxt == PM_WAKE && powerMode_r == PM_DEEP) begin
            oscCnt_r <= OSC_CYCLES[15:0];
        end else if (oscCnt_r != 16'h0000) begin
            oscCnt_r <= oscCnt_r - 16'h0001;
        end
    end

    // ****************************************
    // Clock and supply controls
    // ****************************************
    // Per-mode clock gating and retention
    always_ff @(posedge mclk) begin
        if (fullReset) begin
            powerCtl <= CTL_ACTIVE;
            lowSpeedOscEn <= 1'b1;
            watchCrystalOscEn <= 1'b1;
        end else begin
            powerCtl <= CTL_ACTIVE;
            lowSpeedOscEn <= 1'b1;
            watchCrystalOscEn <= 1'b1;
            unique case (powerMode_nxt)
                PM_ACTIVE: begin
                    powerCtl <= CTL_ACTIVE;
                end
                PM_SLEEP: begin
                    powerCtl.cpuClkEn <= 1'b0;
                    powerCtl.sramRetain <= 1'b1;
                    powerCtl.cpuRetain <= 1'b1;
                end
                PM_DEEP: begin
                    powerCtl <= '0;
                    powerCtl.sramRetain <= 1'b1;
                    powerCtl.cpuRetain <= 1'b1;
                    lowSpeedOscEn <= lowSpeedOscKeep;
                    watchCrystalOscEn <= watchCrystalOscKeep;
                end
                PM_WAKE: begin
                    powerCtl.cpuClkEn <= 1'b0;
                    powerCtl.sramRetain <= 1'b1;
                    powerCtl.cpuRetain <= 1'b1;
                end
            endcase
        end
    end

    // Status outputs
    always_ff @(posedge mclk) begin
        if (fullReset) begin
            powerMode <= PM_ACTIVE;
            opState <= OP_BOOT;
        end else begin
            powerMode <= powerMode_nxt;
            opState <= opState_nxt;
        end
    end

endmodule
`default_nettype wire

// File: verification/pmc_properties.sv
`default_nettype none
module pmc_properties
    import pmc_pkg::*;
#(
    parameter int ACQ_CYCLES = ACQUIRE_CYCLES,
    parameter int OSC_CYCLES = OSC_START_CYCLES
) (
    // Clock and reset causes
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic externalResetPin,
    input wire logic brownoutReset,
    // Requests and wakeups
    input wire logic waitForInterrupt,
    input wire logic deepSleepSelect,
    input wire logic systemCall,
    input wire logic debugConnect,
    input wire logic [1:0] protMode,
    input wire logic [WK_WIDTH-1:0] deepWakeIrq,
    input wire logic anyEnabledIrq,
    input wire logic deepRegulatorReady,
    input wire logic lowSpeedOscKeep,
    input wire logic watchCrystalOscKeep,
    // Controller outputs
    input wire logic lowSpeedOscEn,
    input wire logic watchCrystalOscEn,
    input wire powerCtl_t powerCtl,
    input wire logic irqEnable,
    input wire logic debugGrant,
    input wire logic romExec,
    input wire powerMode_t powerMode,
    input wire opState_t opState
);
    // ********
    // Mode and state checks
    // ********
    localparam int WAKE_MAX = OSC_CYCLES + 2;
    wire logic rc = externalResetPin | brownoutReset;
    wire logic goDeep = deepSleepSelect & deepRegulatorReady;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_cause_reset: assert property (rc |=> powerMode == PM_ACTIVE && opState == OP_BOOT)
        else $error("reset cause left a low power mode");
    a_boot_quiet: assert property (opState == OP_BOOT |-> !irqEnable && romExec)
        else $error("irq or rom wrong in boot");
    a_priv_entry: assert property ($rose(opState == OP_PRIV) |->
        $past(systemCall) && $past(opState) == OP_USER && romExec) else $error("bad priv entry");
    a_grant_debug: assert property (debugGrant |-> opState == OP_DEBUG)
        else $error("debug granted outside debug");
    a_debug_gate: assert property ($rose(opState == OP_DEBUG) |->
        $past(debugConnect) && $past(protMode) == PROT_OPEN) else $error("bad debug entry");
    a_wfi_entry: assert property (opState == OP_USER && powerMode == PM_ACTIVE
        && waitForInterrupt && !rc |=> powerMode == ($past(goDeep) ? PM_DEEP : PM_SLEEP))
        else $error("wrong low power entry");
    a_sleep_wake: assert property (powerMode == PM_SLEEP && anyEnabledIrq && !rc
        |=> powerMode == PM_ACTIVE) else $error("sleep not woken");
    a_deep_move: assert property (powerMode == PM_DEEP && !rc |=> powerMode ==
        ($past(deepWakeIrq) != 4'h0 ? PM_WAKE : PM_DEEP)) else $error("bad deep wakeup");
    a_deep_ctl: assert property (powerMode == PM_DEEP |-> powerCtl == 8'h03)
        else $error("deep controls wrong");
    a_wake_seq: assert property ($rose(powerMode == PM_WAKE) |-> powerCtl == 8'h7F
        ##[1:WAKE_MAX] powerMode == PM_ACTIVE && powerCtl == CTL_ACTIVE)
        else $error("bad oscillator restart");
    a_osc_keep: assert property (powerMode == PM_DEEP |->
        lowSpeedOscEn == $past(lowSpeedOscKeep) && watchCrystalOscEn == $past(watchCrystalOscKeep))
        else $error("slow oscillator option not followed");
    a_osc_awake: assert property (powerMode != PM_DEEP |-> lowSpeedOscEn && watchCrystalOscEn)
        else $error("slow oscillator off while awake");
    c_wake: cover property (powerMode == PM_WAKE);
    c_deep: cover property (powerMode == PM_DEEP);
    c_debug: cover property (debugGrant);
    c_priv: cover property (opState == OP_PRIV);
endmodule
bind power_mode_controller pmc_properties #(
    .ACQ_CYCLES(ACQ_CYCLES),
    .OSC_CYCLES(OSC_CYCLES)
) pmc_properties_inst (.mclk, .sys_rst, .externalResetPin, .brownoutReset, .waitForInterrupt,
    .deepSleepSelect, .systemCall, .debugConnect, .protMode, .deepWakeIrq, .anyEnabledIrq,
    .deepRegulatorReady, .lowSpeedOscKeep, .watchCrystalOscKeep, .lowSpeedOscEn,
    .watchCrystalOscEn, .powerCtl, .irqEnable, .debugGrant, .romExec, .powerMode, .opState);
`default_nettype wire

// File: verification/cpu_core_model.sv
`default_nettype none
module cpu_core_model #(
    parameter int BOOT_AT = 8
) (
    // Clock, any reset cause, command
    input wire logic mclk,
    input wire logic rst,
    input wire logic [2:0] op,
    // Requests to the controller
    output logic waitForInterrupt,
    output logic deepSleepSelect,
    output logic systemCall,
    output logic privExit,
    output logic bootDone
);
    // ********
    // Core requests
    // ********
    int cnt;
    // One-cycle requests decoded from the command
    assign systemCall = op == 3'h1;
    assign privExit = op == 3'h2;
    assign waitForInterrupt = op[2];
    assign deepSleepSelect = op[0];
    // Boot firmware ends well after the acquire window
    always_ff @(posedge mclk) begin
        cnt <= rst ? 0 : (cnt < BOOT_AT ? cnt + 1 : cnt);
    end
    assign bootDone = cnt == BOOT_AT - 1;
endmodule
`default_nettype wire

// File: verification/power_mode_controller_bench.sv
`default_nettype none
module power_mode_controller_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import pmc_pkg::*;
    // ********
    // Stimulus and checking
    // ********
    logic mclk = 1'b0, sys_rst = 1'b1, externalResetPin = 1'b0, brownoutReset = 1'b0;
    logic debugConnect = 1'b0, debugReq = 1'b1, anyEnabledIrq = 1'b0;
    logic deepRegulatorReady = 1'b0, lowSpeedOscKeep = 1'b0, watchCrystalOscKeep = 1'b0;
    logic [1:0] protMode = 2'h0;
    logic [2:0] op = 3'h0;
    logic [WK_WIDTH-1:0] deepWakeIrq = 4'h0;
    logic waitForInterrupt, deepSleepSelect, systemCall, privExit, bootDone;
    logic lowSpeedOscEn, watchCrystalOscEn, irqEnable, debugGrant, romExec;
    powerCtl_t powerCtl;
    powerMode_t powerMode;
    opState_t opState;
    logic [23:0] notes[$];
    logic [23:0] nt;
    logic [3:0] last = 4'h0;
    logic [31:0] seed = 32'h00016BED;
    int fails = 0, checked = 0;
    power_mode_controller #(.ACQ_CYCLES(4), .OSC_CYCLES(2)) power_mode_controller_inst (.mclk,
        .sys_rst, .externalResetPin, .brownoutReset, .waitForInterrupt, .deepSleepSelect,
        .systemCall, .privExit, .bootDone, .debugConnect, .debugReq, .protMode, .deepWakeIrq,
        .anyEnabledIrq, .deepRegulatorReady, .lowSpeedOscKeep, .watchCrystalOscKeep, .powerCtl,
        .lowSpeedOscEn, .watchCrystalOscEn, .irqEnable, .debugGrant, .romExec, .powerMode,
        .opState);
    cpu_core_model #(.BOOT_AT(8)) cpu_core_model_inst (.mclk,
        .rst(sys_rst | externalResetPin | brownoutReset), .op, .waitForInterrupt,
        .deepSleepSelect, .systemCall, .privExit, .bootDone);
    initial forever #10 mclk = ~mclk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic note(input logic [11:0] m, input logic [11:0] v);
        notes.push_back({m, v});
    endtask
    task automatic req(input logic [2:0] c);
        @(negedge mclk);
        op = c;
        @(negedge mclk);
        op = 3'h0;
    endtask
    task automatic restart(input logic [1:0] pm, input logic dc);
        sys_rst = 1'b1;
        protMode = pm;
        cyc(2);
        sys_rst = 1'b0;
        debugConnect = dc;
        cyc(12);
        debugConnect = 1'b0;
    endtask
    task automatic chk(input logic [11:0] m, input logic [11:0] v, input logic [11:0] g);
        checked++;
        if ((g & m) !== v) begin
            fails++;
            $display("BAD %0t exp %h got %h", $time, v, g & m);
        end
    endtask
    task automatic tally_and_finish();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Each state change takes the oldest note; none left means unexpected
    always @(posedge mclk) begin
        #1;
        if ({powerMode, opState} !== last) begin
            nt = notes.size() ? notes.pop_front() : 24'hFFFXXX;
            chk(nt[23:12], nt[11:0], {powerMode, opState, powerCtl});
            last = {powerMode, opState};
        end
    end
    // Watchdog
    initial begin
        repeat (3000) @(posedge mclk);
        fails++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        {lowSpeedOscKeep, watchCrystalOscKeep} = 2'(rnd());
        note(12'hFFF, 12'h1FC);
        restart(2'h0, 1'b0);
        debugConnect = 1'b1;
        note(12'hFFF, 12'h2FC);
        req(3'h1);
        note(12'hFFF, 12'h1FC);
        req(3'h2);
        req(3'h2);
        debugConnect = 1'b0;
        note(12'hF82, 12'h502);
        req(3'h4);
        deepWakeIrq = 4'hF;
        cyc(2);
        note(12'hFFF, 12'h1FC);
        deepWakeIrq = 4'h0;
        anyEnabledIrq = 1'b1;
        cyc(1);
        anyEnabledIrq = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (i == 0) note(12'hF82, 12'h502);
            note(12'hFFF, 12'h903);
            note(12'hFFF, 12'hD7F);
            note(12'hFFF, 12'h1FC);
            req(3'h5);
            deepRegulatorReady = 1'b1;
            cyc(1);
            anyEnabledIrq = 1'b1;
            cyc(3);
            anyEnabledIrq = 1'b0;
            deepWakeIrq = (i < 4) ? 4'h1 << i : 4'(rnd() | 32'h1);
            cyc(1);
            deepWakeIrq = 4'h0;
            cyc(6);
        end
        for (int i = 0; i < 2; i++) begin
            note(i ? 12'hF82 : 12'hFFF, i ? 12'h502 : 12'h903);
            note(12'hFFF, 12'h0FC);
            note(12'hFFF, 12'h1FC);
            req(i ? 3'h4 : 3'h5);
            {brownoutReset, externalResetPin} = i ? 2'h2 : 2'h1;
            cyc(1);
            {brownoutReset, externalResetPin} = 2'h0;
            cyc(12);
        end
        for (int p = 3; p >= 0; p--) begin
            note(12'hFFF, 12'h0FC);
            note(12'hFFF, p ? 12'h1FC : 12'h3FC);
            restart(p[1:0], 1'b1);
        end
        req(3'h1);
        cyc(4);
        if (notes.size() != 0) chk(12'hFFF, 12'hXXX, 12'h000);
        tally_and_finish();
    end
endmodule
`default_nettype wire
